/* src/iat_pkg.sv */
/*
 ignition advance timing constants: timer width, prescale, speed thresholds,
 gate pulse width. assumes a 100 MHz system clock.
*/
package iat_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned TMR_W           = 16;
   // timer tick = 1 us; 16 bits cover periods up to 65.5 ms (~916 rpm)
   localparam int unsigned TICK_NS         = 1000;
   localparam int unsigned TICK_CYC        = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned US_PER_MIN      = 60_000_000;
   localparam logic [15:0] RPM_LOW         = 16'h0bb8;
   localparam logic [15:0] RPM_HIGH        = 16'h1f40;
   localparam int unsigned GATE_US         = 100;
   localparam int unsigned GATE_CYC        = (GATE_US * (CLK_HZ / 1_000_000) > 0) ?
                                             GATE_US * (CLK_HZ / 1_000_000) : 1;
   localparam logic [15:0] PERIOD_RST      = 16'hffff;
   localparam logic [4:0]  MAX_ADV_DEG     = 5'h19;
endpackage

/* src/iat_ignition_advance_timing.sv */
/*
 ignition advance timing: measures pulser period, picks firing point,
 drives thyristor gate and analog bypass switch.
 assumes shaped pulser inputs are clean, one-cycle-or-longer levels
 synchronous to ref_clk_i.
*/
// Contract
// - low speed: fire on negative pulse
// - high speed: fire on positive pulse
// - mid speed: advance proportional to speed
// - 16-bit timer measures pulse period
// - mid speed: fire after delay from positive
// - bypass switch asserted once operational
// - then device is sole firing source
// - spark drives thyristor gate pulse
`timescale 1ns/1ns
`default_nettype none
module iat_ignition_advance_timing
   import iat_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        pulse_pos_i,
   input  wire logic        pulse_neg_i,
   output logic             scr_gate_o,
   output logic             analog_bypass_switch_o,
   output logic [15:0]      rpm_o
);
   ////////////////////////////////////////////////////////////////
   logic       rst_s1_b_reg;
   logic       rst_b_reg;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_b_reg <= 1'b0;
         rst_b_reg    <= 1'b0;
      end else begin
         rst_s1_b_reg <= 1'b1;
         rst_b_reg    <= rst_s1_b_reg;
      end
   end

   ////////////////////////////////////////////////////////////////
   logic pos_d_reg;
   logic neg_d_reg;
   logic pos_edge;
   logic neg_edge;
   always_ff @(posedge ref_clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         pos_d_reg <= 1'b0;
         neg_d_reg <= 1'b0;
      end else begin
         pos_d_reg <= pulse_pos_i;
         neg_d_reg <= pulse_neg_i;
      end
   end
   assign pos_edge = pulse_pos_i & ~pos_d_reg;
   assign neg_edge = pulse_neg_i & ~neg_d_reg;

   ////////////////////////////////////////////////////////////////
   // microsecond tick prescaler
   logic [7:0] pre_reg;
   logic       tick;
   assign tick = (pre_reg == 8'(TICK_CYC - 1));
   always_ff @(posedge ref_clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         pre_reg <= 8'h00;
      end else begin
         pre_reg <= tick ? 8'h00 : pre_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////
   // period timer, saturates so a stalled engine reads as slowest
   logic [TMR_W-1:0] tmr_reg;
   logic [TMR_W-1:0] period_reg;
   logic             have_period_reg;
   always_ff @(posedge ref_clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         tmr_reg         <= 16'h0000;
         period_reg      <= PERIOD_RST;
         have_period_reg <= 1'b0;
      end else if (pos_edge) begin
         period_reg      <= tmr_reg;
         have_period_reg <= 1'b1;
         tmr_reg         <= 16'h0000;
      end else if (tick && tmr_reg != 16'hffff) begin
         tmr_reg <= tmr_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////
   // rpm = 60e6 / period_us; one divider, iterative, 32 cycles
   logic [31:0] div_rem_reg;
   logic [31:0] div_quo_reg;
   logic [5:0]  div_cnt_reg;
   logic        div_busy_reg;
   logic [15:0] rpm_reg;
   logic [32:0] div_trial;
   assign div_trial = {div_rem_reg, div_quo_reg[31]} - {17'h00000, period_reg};
   always_ff @(posedge ref_clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         div_rem_reg  <= 32'h00000000;
         div_quo_reg  <= 32'h00000000;
         div_cnt_reg  <= 6'h00;
         div_busy_reg <= 1'b0;
         rpm_reg      <= 16'h0000;
      end else if (pos_edge) begin
         div_rem_reg  <= 32'h00000000;
         div_quo_reg  <= 32'(US_PER_MIN);
         div_cnt_reg  <= 6'h20;
         div_busy_reg <= (tmr_reg != 16'h0000);
      end else if (div_busy_reg) begin
         if (!div_trial[32]) begin
            div_rem_reg <= div_trial[31:0];
            div_quo_reg <= {div_quo_reg[30:0], 1'b1};
         end else begin
            div_rem_reg <= {div_rem_reg[30:0], div_quo_reg[31]};
            div_quo_reg <= {div_quo_reg[30:0], 1'b0};
         end
         div_cnt_reg <= div_cnt_reg - 6'h01;
         if (div_cnt_reg == 6'h01) begin
            div_busy_reg <= 1'b0;
         end
      end else if (div_cnt_reg == 6'h00 && have_period_reg) begin
         rpm_reg <= (div_quo_reg[31:16] != 16'h0000) ? 16'hffff : div_quo_reg[15:0];
      end
   end
   assign rpm_o = rpm_reg;

   ////////////////////////////////////////////////////////////////
   // delay from positive pulse: window (pos->neg span) times (1 - frac),
   // frac = (rpm-low)/(high-low); approximated by linear interpolation on
   // the 25 degree window measured in timer ticks
   logic [15:0] win_reg;
   logic [15:0] win_cnt_reg;
   logic        in_win_reg;
   always_ff @(posedge ref_clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         win_reg     <= 16'hffff;
         win_cnt_reg <= 16'h0000;
         in_win_reg  <= 1'b0;
      end else if (pos_edge) begin
         in_win_reg  <= 1'b1;
         win_cnt_reg <= 16'h0000;
      end else if (neg_edge && in_win_reg) begin
         in_win_reg <= 1'b0;
         win_reg    <= win_cnt_reg;
      end else if (in_win_reg && tick && win_cnt_reg != 16'hffff) begin
         win_cnt_reg <= win_cnt_reg + 16'h0001;
      end
   end

   function automatic logic [15:0] iat_delay(input logic [15:0] rpm, input logic [15:0] win);
      logic [31:0] num;
      num = 32'(RPM_HIGH - rpm) * 32'(win);
      return 16'(num / 32'(RPM_HIGH - RPM_LOW));
   endfunction

   typedef enum logic [1:0] {
      IAT_LOW  = 2'b00,
      IAT_MID  = 2'b01,
      IAT_HIGH = 2'b10
   } iat_mode_e;
   iat_mode_e mode;
   always_comb begin
      if (rpm_reg <= RPM_LOW) begin
         mode = IAT_LOW;
      end else if (rpm_reg >= RPM_HIGH) begin
         mode = IAT_HIGH;
      end else begin
         mode = IAT_MID;
      end
   end

   // a turn keeps the mode seen at its positive edge, so a fresh rpm landing
   // mid-turn cannot drop the spark due at the negative edge
   iat_mode_e rev_mode_reg;
   always_ff @(posedge ref_clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         rev_mode_reg <= IAT_LOW;
      end else if (pos_edge) begin
         rev_mode_reg <= mode;
      end
   end

   ////////////////////////////////////////////////////////////////
   logic [15:0] dly_reg;
   logic        dly_run_reg;
   logic        fire;
   always_ff @(posedge ref_clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         dly_reg     <= 16'h0000;
         dly_run_reg <= 1'b0;
      end else if (pos_edge && mode == IAT_MID) begin
         dly_reg     <= iat_delay(rpm_reg, win_reg);
         dly_run_reg <= 1'b1;
      end else if (dly_run_reg && (dly_reg == 16'h0000 || neg_edge)) begin
         dly_run_reg <= 1'b0;
      end else if (dly_run_reg && tick) begin
         dly_reg <= dly_reg - 16'h0001;
      end
   end

   always_comb begin
      fire = 1'b0;
      if (pos_edge) begin
         fire = (mode == IAT_HIGH);
      end else begin
         case (rev_mode_reg)
            IAT_LOW:  fire = neg_edge;
            // neg pulse backstops a late delay so a spark is never skipped
            IAT_MID:  fire = dly_run_reg && (dly_reg == 16'h0000 || neg_edge);
            default:  fire = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   logic [15:0] gate_cnt_reg;
   logic        gate_reg;
   always_ff @(posedge ref_clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         gate_cnt_reg <= 16'h0000;
         gate_reg     <= 1'b0;
      end else if (fire && analog_bypass_switch_o) begin
         gate_cnt_reg <= 16'(GATE_CYC - 1);
         gate_reg     <= 1'b1;
      end else if (gate_cnt_reg != 16'h0000) begin
         gate_cnt_reg <= gate_cnt_reg - 16'h0001;
      end else begin
         gate_reg <= 1'b0;
      end
   end
   assign scr_gate_o = gate_reg;

   // operational once out of reset: analog path stays disabled thereafter
   logic bypass_reg;
   always_ff @(posedge ref_clk_i or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         bypass_reg <= 1'b0;
      end else begin
         bypass_reg <= 1'b1;
      end
   end
   assign analog_bypass_switch_o = bypass_reg;
endmodule
`default_nettype wire

/* testbench/iat_chk.sv */
/* port checker for ignition advance timing.
 assumes bind to the design top, single clock. */
`timescale 1ns/1ns
`default_nettype none
module iat_chk
   import iat_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        rst_b_i,
   input wire logic        pulse_pos_i,
   input wire logic        pulse_neg_i,
   input wire logic        scr_gate_o,
   input wire logic        analog_bypass_switch_o,
   input wire logic [15:0] rpm_o
);
   logic        pos_d;
   logic        neg_d;
   logic [15:0] gate_cnt;
   logic [15:0] lat_rpm;
   logic [5:0]  since_pos;
   wire         rise_p = pulse_pos_i & ~pos_d;
   wire         rise_n = pulse_neg_i & ~neg_d;
   wire         armed  = analog_bypass_switch_o & ~scr_gate_o;
   // mode of a revolution is the rpm held when its positive edge arrives
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pos_d     <= 1'b0;
         neg_d     <= 1'b0;
         gate_cnt  <= 16'h0000;
         lat_rpm   <= 16'h0000;
         since_pos <= 6'h3f;
      end else begin
         pos_d     <= pulse_pos_i;
         neg_d     <= pulse_neg_i;
         gate_cnt  <= scr_gate_o ? gate_cnt + 16'h0001 : 16'h0000;
         lat_rpm   <= rise_p ? rpm_o : lat_rpm;
         since_pos <= rise_p ? 6'h00 : (since_pos == 6'h3f ? since_pos : since_pos + 6'h01);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_fire;
      ##1 scr_gate_o;
   endsequence
   a_gate_width: assert property ($fell(scr_gate_o) |-> gate_cnt == GATE_CYC)
      else $error("gate width");
   a_gate_bypass: assert property (scr_gate_o |-> analog_bypass_switch_o)
      else $error("gate before bypass");
   a_bypass_start: assert property ($rose(rst_b_i) |-> ##[1:3] analog_bypass_switch_o)
      else $error("bypass late");
   a_bypass_held: assert property (analog_bypass_switch_o |=> analog_bypass_switch_o)
      else $error("bypass dropped");
   a_low_neg: assert property (rise_n && lat_rpm < RPM_LOW && armed |-> s_fire)
      else $error("low fire missed");
   a_low_only: assert property ($rose(scr_gate_o) && lat_rpm < RPM_LOW |-> $past(rise_n))
      else $error("low fire off neg");
   a_high_pos: assert property (rise_p && rpm_o > RPM_HIGH && armed |-> s_fire)
      else $error("high fire missed");
   a_rpm_update: assert property ($changed(rpm_o) |-> since_pos <= 6'h28)
      else $error("rpm update time");
endmodule
`default_nettype wire

/* testbench/iat_pulser_model.sv */
/* pulser model: shaped positive then negative pulse per turn.
 assumes the bench calls rev from its sequence. */
`timescale 1ns/1ns
`default_nettype none
module iat_pulser_model (
   input  wire logic ref_clk_i,
   output var logic  pulse_pos_o = 1'b0,
   output var logic  pulse_neg_o = 1'b0
);
   // gap and span in clock cycles; idle level low
   task automatic rev(input int gap, input int span);
      repeat (gap) @(posedge ref_clk_i);
      #1 pulse_pos_o = 1'b1;
      repeat (50) @(posedge ref_clk_i);
      #1 pulse_pos_o = 1'b0;
      repeat (span) @(posedge ref_clk_i);
      #1 pulse_neg_o = 1'b1;
      repeat (50) @(posedge ref_clk_i);
      #1 pulse_neg_o = 1'b0;
   endtask
endmodule
`default_nettype wire

/* testbench/tb_ignition_advance_timing.sv */
/* bench: pulser model drives, a reference predicts fire cycle and rpm.
 assumes 100 MHz clock; long low and mid periods are out of reach. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_ignition_advance_timing;
   import iat_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   logic        pulse_pos;
   logic        pulse_neg;
   logic        scr_gate;
   logic        bypass;
   logic [15:0] rpm;
   logic [15:0] exp_rpm;
   logic        pp = 1'b0;
   logic        np = 1'b0;
   logic        gp = 1'b0;
   int          cyc, pc, nc, gc, error_cnt, n_tests, gap, span, ticks;
   always #5 ref_clk_i = ~ref_clk_i;
   iat_ignition_advance_timing i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .pulse_pos_i(pulse_pos),
      .pulse_neg_i(pulse_neg), .scr_gate_o(scr_gate), .analog_bypass_switch_o(bypass), .rpm_o(rpm));
   iat_pulser_model i_pul (.ref_clk_i(ref_clk_i), .pulse_pos_o(pulse_pos), .pulse_neg_o(pulse_neg));
   // gate launches on the pulse edge, so it is first seen one count later
   always @(posedge ref_clk_i) begin
      cyc++;
      if (pulse_pos && !pp) pc = cyc;
      if (pulse_neg && !np) nc = cyc;
      if (scr_gate === 1'b1 && !gp) gc = cyc;
      pp = pulse_pos;
      np = pulse_neg;
      gp = (scr_gate === 1'b1);
   end
   task test_done;
      if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #900_000;
      error_cnt++;
      test_done;
   end
   initial begin
      void'($urandom(32'h3db9a4e2));
      repeat (3) @(posedge ref_clk_i);
      #1 rst_b_i = 1'b1;
      `CHK(scr_gate, 1'b0)
      repeat (4) @(posedge ref_clk_i);
      `CHK(bypass, 1'b1)
      span = 200 + $urandom % 600;
      i_pul.rev(10, span);
      `CHK(gc - nc, 1)
      for (int r = 0; r < 2; r++) begin
         gap   = 20000 + $urandom % 500;
         // pos-to-pos covers both 50-cycle pulses and the last turn's span
         ticks = (gap + 100 + span) / TICK_CYC;
         span  = 200 + $urandom % 600;
         i_pul.rev(gap, span);
         exp_rpm = (US_PER_MIN / ticks > 65535) ? 16'hffff : 16'(US_PER_MIN / ticks);
         `CHK(rpm, exp_rpm)
         if (r == 0) `CHK(gc - nc, 1)
         if (r == 1) `CHK(gc - pc, 1)
      end
      repeat (200) @(posedge ref_clk_i);
      test_done;
   end
endmodule
bind iat_ignition_advance_timing iat_chk i_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
   .pulse_pos_i(pulse_pos_i), .pulse_neg_i(pulse_neg_i), .scr_gate_o(scr_gate_o),
   .analog_bypass_switch_o(analog_bypass_switch_o), .rpm_o(rpm_o));
`default_nettype wire
